// ### hw/expander_cfg.svh
// constants for the two-wire input expander access block
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

// fixed upper slave address bits a6..a4
`define ADDR_FIXED      3'h6
// register byte offsets on the avalon side
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_LOG         4'h8
`define REG_LEVEL       4'hC
// control register fields and reset value
`define CTRL_EN_BIT     0
`define CTRL_RESET      1'h1
// status register field positions
`define ST_MASK_LSB     0
`define ST_FLAGS_LSB    8
`define ST_SNAP_LSB     16
`define ST_ALERT_BIT    24
`define ST_BUSY_BIT     25
// log register valid flag position
`define LOG_VALID_BIT   8
// reset values of the expander state
`define MASK_RESET      8'h00
`define FLAGS_RESET     8'h00
// mask byte log fifo shape
`define LOG_WIDTH       8
`define LOG_DEPTH       32
`define LOG_LEVEL_W     6
// cycles after reset release before straps and inputs are caught
`define PRIME_CYCLES    2'h3

`endif

// ### hw/expander_pkg.sv
// types shared by the input expander access design
package expander_pkg;

  // serial link states, gray coded along the usual path
  typedef enum logic [2:0] {
    LINK_IDLE   = 3'h0,
    LINK_ADDR   = 3'h1,
    LINK_AACK   = 3'h3,
    LINK_RX     = 3'h2,
    LINK_RACK   = 3'h6,
    LINK_TX     = 3'h7,
    LINK_TACK   = 3'h5,
    LINK_IGNORE = 3'h4
  } link_state_type;

endpackage

// ### hw/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int LW    = $clog2(DEPTH) + 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic      [LW-1:0]    level_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    wr_nxt;
  logic [PW-1:0]    rd_r;
  logic [PW-1:0]    rd_nxt;
  logic [LW-1:0]    cnt_r;
  logic [LW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  // honest full and empty from the count
  assign in_ready_o  = (cnt_r != LW'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_r];
  assign level_o     = cnt_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and count next values
  always_comb begin
    wr_nxt  = push ? PW'(wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? PW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = LW'(cnt_r + 1'b1);
    end else if (pop & ~push) begin
      cnt_nxt = LW'(cnt_r - 1'b1);
    end
  end

  // pointer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ### hw/input_expander.sv
// two-wire slave access logic of an eight-input port expander
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`include "expander_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module input_expander
  import expander_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  // two-wire bus pins
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  // address straps
  input  wire logic [1:0]  ADDR_STRAP_LOW_I,
  input  wire logic [1:0]  ADDR_STRAP_HIGH_I,
  // monitored inputs
  input  wire logic [7:0]  INPUT_LINES_I,
  // open-drain change alert
  output logic             ALERT_N_O,
  output logic             ALERT_OE_O,
  // avalon-mm register slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);

  // edge helpers on synchronised levels
  function automatic logic rising(input logic now, input logic prev);
    rising = now & ~prev;
  endfunction

  function automatic logic falling(input logic now, input logic prev);
    falling = ~now & prev;
  endfunction

  // pin synchronisers
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [7:0] in_meta_r;
  logic [7:0] in_s_r;
  logic [3:0] strap_meta_r;
  logic [3:0] strap_s_r;
  logic       scl_d_r;
  logic       sda_d_r;

  // pin synchronisers and one-cycle history
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      scl_sync_r   <= 2'h3;
      sda_sync_r   <= 2'h3;
      in_meta_r    <= 8'h00;
      in_s_r       <= 8'h00;
      strap_meta_r <= 4'h0;
      strap_s_r    <= 4'h0;
      scl_d_r      <= 1'b1;
      sda_d_r      <= 1'b1;
    end else begin
      scl_sync_r   <= {scl_sync_r[0], SCL_I};
      sda_sync_r   <= {sda_sync_r[0], SDA_I};
      in_meta_r    <= INPUT_LINES_I;
      in_s_r       <= in_meta_r;
      strap_meta_r <= {ADDR_STRAP_HIGH_I, ADDR_STRAP_LOW_I};
      strap_s_r    <= strap_meta_r;
      scl_d_r      <= scl_sync_r[1];
      sda_d_r      <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // bus events from synchronised levels
  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = rising(scl_s, scl_d_r);
  assign scl_fall  = falling(scl_s, scl_d_r);
  assign bus_start = scl_s & scl_d_r & falling(sda_s, sda_d_r);
  assign bus_stop  = scl_s & scl_d_r & rising(sda_s, sda_d_r);

  // expander state
  logic [1:0] prime_r;
  logic [1:0] prime_nxt;
  logic [3:0] addr_low_r;
  logic [3:0] addr_low_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] ref_r;
  logic [7:0] ref_nxt;
  logic [7:0] snap_r;
  logic [7:0] snap_nxt;
  logic [7:0] txflags_r;
  logic [7:0] txflags_nxt;
  logic       alert_n_r;
  logic       alert_n_nxt;
  logic [7:0] diff;
  logic       primed;

  // serial link state
  link_state_type state_r;
  link_state_type state_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic       full_r;
  logic       full_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       sel_r;
  logic       sel_nxt;
  logic       sda_low_r;
  logic       sda_low_nxt;
  logic       xfer_r;
  logic       xfer_nxt;
  logic       snap_now;
  logic       clear_now;
  logic       mask_load;
  logic       addr_match;

  // register bus and log fifo
  logic        en_r;
  logic        en_nxt;
  logic        bus_ack_r;
  logic        bus_ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        log_ready;
  logic        log_valid;
  logic        log_pop;
  logic [7:0]  log_data;
  logic [`LOG_LEVEL_W-1:0] log_level;

  assign primed = (prime_r == `PRIME_CYCLES);
  assign diff   = in_s_r ^ ref_r;

  // fixed upper bits, strap nibble below, rw bit last
  assign addr_match = en_r && primed &&
                      shift_r[7:5] == `ADDR_FIXED &&
                      shift_r[4:1] == addr_low_r;

  // two-wire slave sequencing
  always_comb begin
    state_nxt   = state_r;
    shift_nxt   = shift_r;
    bit_nxt     = bit_r;
    full_nxt    = full_r;
    rw_nxt      = rw_r;
    sel_nxt     = sel_r;
    sda_low_nxt = sda_low_r;
    xfer_nxt    = xfer_r;
    snap_now    = 1'b0;
    clear_now   = 1'b0;
    mask_load   = 1'b0;
    if (bus_stop) begin
      state_nxt   = LINK_IDLE;
      sda_low_nxt = 1'b0;
      xfer_nxt    = 1'b0;
    end else if (bus_start) begin
      state_nxt   = LINK_ADDR;
      bit_nxt     = 3'h0;
      full_nxt    = 1'b0;
      sda_low_nxt = 1'b0;
    end else begin
      case (state_r)
        LINK_ADDR, LINK_RX: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_nxt   = 3'(bit_r + 1'b1);
            full_nxt  = (bit_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            if (state_r == LINK_ADDR) begin
              if (addr_match) begin
                state_nxt   = LINK_AACK;
                sda_low_nxt = 1'b1;
                rw_nxt      = shift_r[0];
                sel_nxt     = 1'b0;
                xfer_nxt    = 1'b1;
                snap_now    = 1'b1;
                clear_now   = shift_r[0];
              end else begin
                state_nxt = LINK_IGNORE;
              end
            end else if (log_ready) begin
              state_nxt   = LINK_RACK;
              sda_low_nxt = 1'b1;
              mask_load   = 1'b1;
              clear_now   = 1'b1;
            end else begin
              state_nxt = LINK_IGNORE;
            end
          end
        end
        LINK_AACK, LINK_RACK: begin
          if (scl_fall) begin
            bit_nxt = 3'h0;
            if (state_r == LINK_AACK && rw_r) begin
              state_nxt   = LINK_TX;
              shift_nxt   = {snap_r[6:0], 1'b0};
              sda_low_nxt = ~snap_r[7];
            end else begin
              state_nxt   = LINK_RX;
              sda_low_nxt = 1'b0;
            end
          end
        end
        LINK_TX: begin
          if (scl_rise) begin
            bit_nxt  = 3'(bit_r + 1'b1);
            full_nxt = (bit_r == 3'h7);
          end else if (scl_fall) begin
            if (full_r) begin
              state_nxt   = LINK_TACK;
              full_nxt    = 1'b0;
              sda_low_nxt = 1'b0;
              sel_nxt     = ~sel_r;
            end else begin
              sda_low_nxt = ~shift_r[7];
              shift_nxt   = {shift_r[6:0], 1'b0};
            end
          end
        end
        LINK_TACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_nxt = LINK_IGNORE;
            end else if (!sel_r) begin
              snap_now  = 1'b1;
              clear_now = 1'b1;
            end
          end else if (scl_fall) begin
            state_nxt   = LINK_TX;
            bit_nxt     = 3'h0;
            shift_nxt   = sel_r ? {txflags_r[6:0], 1'b0} : {snap_r[6:0], 1'b0};
            sda_low_nxt = sel_r ? ~txflags_r[7] : ~snap_r[7];
          end
        end
        LINK_IDLE, LINK_IGNORE: begin
          sda_low_nxt = 1'b0;
        end
        default: begin
          state_nxt   = LINK_IDLE;
          sda_low_nxt = 1'b0;
        end
      endcase
    end
  end

  // serial link registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r   <= LINK_IDLE;
      shift_r   <= 8'h00;
      bit_r     <= 3'h0;
      full_r    <= 1'b0;
      rw_r      <= 1'b0;
      sel_r     <= 1'b0;
      sda_low_r <= 1'b0;
      xfer_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      shift_r   <= shift_nxt;
      bit_r     <= bit_nxt;
      full_r    <= full_nxt;
      rw_r      <= rw_nxt;
      sel_r     <= sel_nxt;
      sda_low_r <= sda_low_nxt;
      xfer_r    <= xfer_nxt;
    end
  end

  // transition detection, mask and alert
  always_comb begin
    prime_nxt    = primed ? prime_r : 2'(prime_r + 1'b1);
    addr_low_nxt = addr_low_r;
    mask_nxt     = mask_load ? shift_r : mask_r;
    ref_nxt      = ref_r;
    snap_nxt     = snap_now ? in_s_r : snap_r;
    txflags_nxt  = txflags_r;
    flags_nxt    = flags_r | diff;
    if (!primed) begin
      addr_low_nxt = strap_s_r;
      ref_nxt      = in_s_r;
      flags_nxt    = `FLAGS_RESET;
    end else if (clear_now) begin
      // new reference is the current input, equal to the value sent when a snapshot is taken, so later edges are caught
      ref_nxt   = in_s_r;
      flags_nxt = snap_now ? `FLAGS_RESET : diff;
      if (snap_now) begin
        txflags_nxt = flags_r | diff;
      end
    end
    // released while addressed, masked-in flags pull low otherwise
    alert_n_nxt = xfer_nxt | ~(|(flags_r & mask_r));
  end

  // detection registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prime_r    <= 2'h0;
      addr_low_r <= 4'h0;
      mask_r     <= `MASK_RESET;
      flags_r    <= `FLAGS_RESET;
      ref_r      <= 8'h00;
      snap_r     <= 8'h00;
      txflags_r  <= 8'h00;
      alert_n_r  <= 1'b1;
    end else begin
      prime_r    <= prime_nxt;
      addr_low_r <= addr_low_nxt;
      mask_r     <= mask_nxt;
      flags_r    <= flags_nxt;
      ref_r      <= ref_nxt;
      snap_r     <= snap_nxt;
      txflags_r  <= txflags_nxt;
      alert_n_r  <= alert_n_nxt;
    end
  end

  // open-drain outputs, enable high while pulling low
  assign SDA_O      = 1'b0;
  assign SDA_OE_O   = sda_low_r;
  assign ALERT_N_O  = alert_n_r;
  assign ALERT_OE_O = ~alert_n_r;

  // log of received mask bytes, back-pressure nacks the byte
  byte_fifo #(
    .WIDTH (`LOG_WIDTH),
    .DEPTH (`LOG_DEPTH),
    .LW    (`LOG_LEVEL_W)
  ) mask_log (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RESETN_I),
    .in_valid_i  (mask_load),
    .in_ready_o  (log_ready),
    .in_data_i   (shift_r),
    .out_valid_o (log_valid),
    .out_ready_i (log_pop),
    .out_data_o  (log_data),
    .level_o     (log_level)
  );

  // one wait cycle, then the answer
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~bus_ack_r;
  assign AVS_READDATA_O    = rdata_r;
  assign log_pop = AVS_READ_I & bus_ack_r & (AVS_ADDRESS_I == `REG_LOG);

  // register bus next values
  always_comb begin
    bus_ack_nxt = (AVS_READ_I | AVS_WRITE_I) & ~bus_ack_r;
    en_nxt      = en_r;
    rdata_nxt   = rdata_r;
    if (AVS_WRITE_I && bus_ack_r && AVS_BYTEENABLE_I[0] &&
        AVS_ADDRESS_I == `REG_CTRL) begin
      en_nxt = AVS_WRITEDATA_I[`CTRL_EN_BIT];
    end
    if (AVS_READ_I && !bus_ack_r) begin
      rdata_nxt = 32'h0000_0000;
      case (AVS_ADDRESS_I)
        `REG_CTRL: begin
          rdata_nxt[`CTRL_EN_BIT] = en_r;
        end
        `REG_STATUS: begin
          rdata_nxt[`ST_MASK_LSB +: 8]  = mask_r;
          rdata_nxt[`ST_FLAGS_LSB +: 8] = flags_r;
          rdata_nxt[`ST_SNAP_LSB +: 8]  = snap_r;
          rdata_nxt[`ST_ALERT_BIT]      = ~alert_n_r;
          rdata_nxt[`ST_BUSY_BIT]       = xfer_r;
        end
        `REG_LOG: begin
          rdata_nxt[7:0]            = log_valid ? log_data : 8'h00;
          rdata_nxt[`LOG_VALID_BIT] = log_valid;
        end
        `REG_LEVEL: begin
          rdata_nxt[`LOG_LEVEL_W-1:0] = log_level;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // register bus registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      en_r      <= `CTRL_RESET;
      bus_ack_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      en_r      <= en_nxt;
      bus_ack_r <= bus_ack_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// ### testbench/input_expander_checker.sv
// pin-level concurrent checks for the expander access block
`timescale 1ns/1ps
`default_nettype none
module input_expander_checker (
  // clock and reset
  input wire logic       CLOCK_I,
  input wire logic       RESETN_I,
  // bus pins and straps
  input wire logic       SCL_I,
  input wire logic       SDA_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic [1:0] ADDR_STRAP_LOW_I,
  input wire logic [1:0] ADDR_STRAP_HIGH_I,
  // inputs and alert
  input wire logic [7:0] INPUT_LINES_I,
  input wire logic       ALERT_N_O,
  input wire logic       ALERT_OE_O
);
  logic       scl_r, sda_r, frame_r, frame_nxt, seen_r, seen_nxt, far_r, far_nxt;
  logic [5:0] sh_r, sh_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [4:0] quiet_r, quiet_nxt;
  logic [7:0] in_r;
  logic       rise, start, stop;
  // raw bus events seen on the pins
  assign rise  = SCL_I & ~scl_r;
  assign start = SCL_I & scl_r & sda_r & ~SDA_I;
  assign stop  = SCL_I & scl_r & ~sda_r & SDA_I;
  // frame, address capture and quiet-time tracking
  always_comb begin
    frame_nxt = (frame_r | start) & ~stop;
    seen_nxt  = (seen_r | (SDA_OE_O & frame_r)) & ~stop & ~start;
    far_nxt   = far_r & ~stop & ~start;
    sh_nxt    = sh_r;
    cnt_nxt   = start ? 4'h0 : cnt_r;
    quiet_nxt = (quiet_r == 5'h1F) ? quiet_r : quiet_r + 5'h01;
    if (stop || INPUT_LINES_I != in_r) quiet_nxt = 5'h00;
    if (rise && cnt_r < 4'h8) begin
      sh_nxt  = {sh_r[4:0], SDA_I};
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == 4'h6)
        far_nxt = {sh_r, SDA_I} != {3'h6, ADDR_STRAP_HIGH_I, ADDR_STRAP_LOW_I};
    end
  end
  // helper registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {scl_r, sda_r, frame_r, seen_r, far_r} <= 5'h18;
      sh_r    <= 6'h00;
      cnt_r   <= 4'h8;
      quiet_r <= 5'h1F;
      in_r    <= 8'h00;
    end else begin
      {scl_r, sda_r, frame_r, seen_r, far_r} <= {SCL_I, SDA_I, frame_nxt, seen_nxt, far_nxt};
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      quiet_r <= quiet_nxt;
      in_r    <= INPUT_LINES_I;
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // first pull of the frame is the address ack
  sequence s_addr_ack;
    $rose(SDA_OE_O) && !seen_r;
  endsequence
  AST_ACK_RELEASE: assert property (s_addr_ack |-> ##[0:4] ALERT_N_O)
    else $error("alert not released at address ack");
  AST_ALERT_HOLD: assert property (seen_r |-> !$fell(ALERT_N_O))
    else $error("alert asserted while addressed");
  AST_FOREIGN: assert property (far_r |-> !SDA_OE_O)
    else $error("foreign address driven");
  AST_OE_PAIR: assert property (ALERT_OE_O == !ALERT_N_O)
    else $error("alert enable not inverse of level");
  AST_SDA_LOW: assert property (SDA_O == 1'b0)
    else $error("data pin value not low");
  AST_OE_SCL_LOW: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data changed while clock high");
  AST_ALERT_CAUSE: assert property ($fell(ALERT_N_O) |-> quiet_r < 5'h10)
    else $error("alert without input change or stop");
  AST_IDLE_FREE: assert property (!frame_r && !$past(frame_r) |-> !SDA_OE_O)
    else $error("data pulled outside frame");
endmodule
`default_nettype wire

// ### testbench/twi_master_model.sv
// two-wire bus master model with open-drain data
`timescale 1ns/1ps
`default_nettype none
module twi_master_model #(
  parameter int HALF = 8
) (
  // clock
  input  wire logic clk_i,
  // bus lines
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  // idle bus with both lines released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  // one clock pulse, data set in low phase, sampled late in high phase
  task automatic pulse(input logic b, output logic s);
    sda_low_o <= ~b;
    repeat (HALF) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    s = sda_i;
    scl_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // data falls while clock high
  task automatic start();
    sda_low_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask
  // data rises while clock high
  task automatic stop();
    sda_low_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask
  // byte out msb first, then release for the slave ack
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(d[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask
  // byte in, acked unless last
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(last, s);
  endtask
endmodule
`default_nettype wire

// ### testbench/input_expander_test.sv
// self-checking bench for the expander access block
`include "expander_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module input_expander_test;
  localparam logic [6:0] DEV = {3'h6, 2'h1, 2'h2};
  logic        clk, rst_n, scl, mst_low, sda_oe, sda_o, alert_n, alert_oe;
  logic        rd_en, wr_en, waitreq;
  logic [7:0]  lines;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata;
  int          checks, n_mismatch, cyc;
  wire logic   sda = ~(sda_oe | mst_low);
  // device under test and bus master
  input_expander DUT (.CLOCK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_STRAP_LOW_I(DEV[1:0]),
    .ADDR_STRAP_HIGH_I(DEV[3:2]), .INPUT_LINES_I(lines), .ALERT_N_O(alert_n),
    .ALERT_OE_O(alert_oe), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq));
  twi_master_model MST (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(mst_low));
  // clock and hang limit
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      results();
    end
  end
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one avalon transfer held until waitrequest low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    addr  <= a;
    wdata <= d;
    be    <= 4'hF;
    rd_en <= ~w;
    wr_en <= w;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    `CHK("waitrequest", 1'b0, waitreq)
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // masked register read and compare
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string n);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    `CHK(n, e, q & m)
  endtask
  // start plus address byte
  task automatic adr(input logic [6:0] a, input logic r, output logic ack);
    MST.start();
    MST.wr({a, r}, ack);
  endtask
  // bounded wait for an alert level
  task automatic wait_alert(input logic e);
    for (int n = 0; n < 40 && alert_n !== e; n++) @(posedge clk);
  endtask
  // reset values, unmapped place, foreign and disabled address
  task automatic t_idle();
    logic        ack;
    logic [31:0] q;
    chk_reg(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk_reg(`REG_STATUS, 32'hFFFF, 32'h0, "status reset");
    chk_reg(`REG_CTRL, 32'h1, 32'h1, "ctrl reset");
    for (int i = 0; i < 2; i++) begin
      adr(DEV ^ (i ? 7'h20 : 7'h01), 1'b0, ack);
      `CHK("foreign ack", 1'b0, ack)
      MST.stop();
    end
    av(1'b1, `REG_CTRL, 32'h0, q);
    adr(DEV, 1'b0, ack);
    `CHK("disabled ack", 1'b0, ack)
    MST.stop();
    av(1'b1, `REG_CTRL, 32'h1, q);
  endtask
  // write until the log refuses, then drain it
  task automatic t_fill();
    logic ack;
    adr(DEV, 1'b0, ack);
    `CHK("write addr ack", 1'b1, ack)
    for (int i = 0; i <= `LOG_DEPTH; i++) begin
      MST.wr(8'(i), ack);
      `CHK("data ack", i < `LOG_DEPTH, ack)
    end
    MST.stop();
    chk_reg(`REG_STATUS, 32'hFF, 32'h1F, "last mask");
    chk_reg(`REG_LEVEL, 32'h3F, 32'h20, "full level");
    for (int i = 0; i < `LOG_DEPTH; i++)
      chk_reg(`REG_LOG, 32'h1FF, {23'h0, 1'b1, 8'(i)}, "log entry");
    chk_reg(`REG_LEVEL, 32'h3F, 32'h0, "drained level");
  endtask
  // single mask byte, unmasked and masked changes
  task automatic t_mask();
    logic ack;
    adr(DEV, 1'b0, ack);
    MST.wr(8'h01, ack);
    MST.stop();
    chk_reg(`REG_STATUS, 32'hFFFF, 32'h0001, "single mask");
    lines <= 8'h02;
    repeat (10) @(posedge clk);
    lines <= 8'h00;
    repeat (10) @(posedge clk);
    chk_reg(`REG_STATUS, 32'hFF00, 32'h0200, "sticky flag");
    `CHK("alert unmasked", 1'b1, alert_n)
    lines <= 8'h01;
    wait_alert(1'b0);
    `CHK("alert masked", 1'b0, alert_n)
    chk_reg(`REG_STATUS, 32'h0300_0000, 32'h0100_0000, "alert bit");
  endtask
  // two-byte read with a change in mid-read
  task automatic t_read2();
    logic       ack;
    logic [7:0] b;
    adr(DEV, 1'b1, ack);
    `CHK("read addr ack", 1'b1, ack)
    `CHK("alert at ack", 1'b1, alert_n)
    MST.rd(1'b0, b);
    `CHK("port byte", 8'h01, b)
    lines <= 8'h00;
    MST.rd(1'b1, b);
    `CHK("flags byte", 8'h03, b)
    `CHK("alert held", 1'b1, alert_n)
    MST.stop();
    wait_alert(1'b0);
    `CHK("alert after stop", 1'b0, alert_n)
    chk_reg(`REG_STATUS, 32'hFF00, 32'h0100, "mid-read flag");
  endtask
  // three-byte read alternates port and flags
  task automatic t_read3();
    logic       ack;
    logic [7:0] b;
    adr(DEV, 1'b1, ack);
    for (int i = 0; i < 3; i++) begin
      MST.rd(i == 2, b);
      `CHK("long read byte", (i == 1) ? 8'h01 : 8'h00, b)
    end
    MST.stop();
    chk_reg(`REG_STATUS, 32'hFF00, 32'h0, "flags cleared");
    `CHK("alert stays off", 1'b1, alert_n)
  endtask
  // reset, then the scenarios in order
  initial begin
    {clk, rst_n, rd_en, wr_en} = 4'h0;
    {checks, n_mismatch, cyc} = '0;
    {lines, addr, be, wdata} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_idle();
    t_fill();
    t_mask();
    t_read2();
    t_read3();
    results();
  end
endmodule
bind input_expander input_expander_checker CHK (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .ADDR_STRAP_LOW_I(ADDR_STRAP_LOW_I), .ADDR_STRAP_HIGH_I(ADDR_STRAP_HIGH_I),
  .INPUT_LINES_I(INPUT_LINES_I), .ALERT_N_O(ALERT_N_O), .ALERT_OE_O(ALERT_OE_O));
`default_nettype wire
